// ==== bcfg_defs.vh ====
/*
 * Constants for the bus configuration register bank: register offsets,
 * field positions, reset values and response codes.
 * Assumes it is included by bare name from the design file and the bench.
 */
// Function
// R01 - priority arbitration when interleave bit clear
// R02 - interleave cpu with dma or transfer controller
// R03 - peripheral writes use buffer only when enabled
// R04 - arbitration bit 1 reads one always
// R05 - arbitration bit 5 reads zero always
// R06 - reserved bits read zero, ignore writes
// R07 - endian bit per area 2-7 selects format
// R08 - internal data big endian; swap externally
// R09 - software keeps code/stack areas big endian
// R10 - sram bit per area picks byte-control interface
// R11 - 8-bit areas never use byte-control sram
// R12 - software clears burst/multiplex before sram select
// R13 - buffering also for external and DMA writes
// R14 - areas 0 and 1 always big endian
`ifndef BCFG_DEFS_VH
`define BCFG_DEFS_VH

`define BCFG_ADDR_W          4
`define BCFG_OFF_ARB         4'h0
`define BCFG_OFF_ENDIAN      4'h4
`define BCFG_OFF_SRAM        4'h8

`define BCFG_ARB_PWB_BIT     0
`define BCFG_ARB_ONE_BIT     1
`define BCFG_ARB_ILV_BIT     4
`define BCFG_ARB_RESET       8'h02
`define BCFG_LE_LSB          2
`define BCFG_LE_MSB          7
`define BCFG_SRAM_LSB        8
`define BCFG_SRAM_MSB        15

`define BCFG_RESP_OKAY       2'h0
`define BCFG_RESP_SLVERR     2'h2

`define BCFG_SIZE_BYTE       2'h0
`define BCFG_SIZE_WORD       2'h1
`define BCFG_SIZE_LONG       2'h2

`endif

// ==== bcfg_bus_config.v ====
/*
 * Bus controller configuration bank: arbitration/peripheral write-buffer
 * control, per-area endian select and per-area byte-control sram select,
 * plus the small pieces of logic those settings steer.
 * Assumes an AXI4-Lite master on sys_clk and request/area inputs that are
 * synchronous to sys_clk.
 */
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`include "bcfg_defs.vh"
`default_nettype none

module bcfg_bus_config (
    input  wire        sys_clk,
    input  wire        rst_b,
    // axi4-lite slave
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // internal bus arbitration
    input  wire        cpu_req,
    input  wire        dma_controller_req,
    input  wire        data_transfer_controller_req,
    output reg         cpu_grant,
    output reg         dma_controller_grant,
    output reg         data_transfer_controller_grant,
    // write data buffer steering
    input  wire        periph_write_req,
    input  wire        ext_write_req,
    input  wire        dma_single_write_req,
    input  wire        external_write_buffer_enable,
    output reg         periph_write_buffered,
    output reg         periph_write_direct,
    output reg         ext_write_buffered,
    output reg         ext_write_direct,
    // external area access
    input  wire [2:0]  ext_area,
    input  wire [1:0]  ext_size,
    input  wire [31:0] ext_wdata,
    input  wire [7:0]  area_bus_width_control,
    output reg  [31:0] ext_bus_data,
    output reg         ext_little_endian,
    output reg  [7:0]  area_byte_ctrl_sram
);

    reg        rst_meta;
    reg        rst_sync;
    reg        arbiter_interleave_select;
    reg        periph_write_buffer_enable;
    reg [7:2]  area_little_endian;
    reg [7:0]  area_sram_select;
    reg        last_cpu;
    reg        ext_wbuf_en;
    reg        aw_held;
    reg        w_held;
    reg [`BCFG_ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    wire [`BCFG_ADDR_W-1:0] aw_cur;
    wire [31:0]             wd_cur;
    wire [3:0]              ws_cur;
    wire                    aw_have;
    wire                    w_have;
    wire                    do_write;
    wire                    do_read;
    wire                    side_req;
    wire                    area_le;

    // decode one offset; the upper address bits must be clear for a hit
    function [2:0] reg_hit;
        input [31:0] addr;
        begin
            reg_hit = 3'h0;
            if (addr[31:`BCFG_ADDR_W] != 28'h0000000) begin
                reg_hit = 3'h0;
            end else if (addr[`BCFG_ADDR_W-1:0] == `BCFG_OFF_ARB) begin
                reg_hit = 3'h1;
            end else if (addr[`BCFG_ADDR_W-1:0] == `BCFG_OFF_ENDIAN) begin
                reg_hit = 3'h2;
            end else if (addr[`BCFG_ADDR_W-1:0] == `BCFG_OFF_SRAM) begin
                reg_hit = 3'h4;
            end
        end
    endfunction

    // reordering bytes of the big-endian internal word for the external bus
    function [31:0] le_swap;
        input [31:0] d;
        input [1:0]  size;
        begin
            le_swap = d;
            if (size == `BCFG_SIZE_WORD) begin
                le_swap = {d[23:16], d[31:24], d[7:0], d[15:8]};
            end else if (size == `BCFG_SIZE_LONG) begin
                le_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
            end
        end
    endfunction

    // reset released through two flops; asserted asynchronously
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // address and data may come in either order; each is held until both are here
    assign aw_have  = aw_held | (s_axi_awvalid & s_axi_awready);
    assign w_have   = w_held | (s_axi_wvalid & s_axi_wready);
    assign aw_cur   = aw_held ? aw_addr : s_axi_awaddr[`BCFG_ADDR_W-1:0];
    assign wd_cur   = w_held ? w_data : s_axi_wdata;
    assign ws_cur   = w_held ? w_strb : s_axi_wstrb;
    assign do_write = aw_have & w_have & ~s_axi_bvalid;
    assign do_read  = s_axi_arvalid & s_axi_arready;

    reg aw_bad;
    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BCFG_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= {`BCFG_ADDR_W{1'b0}};
            aw_bad        <= 1'b0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_addr <= s_axi_awaddr[`BCFG_ADDR_W-1:0];
                aw_bad  <= (reg_hit(s_axi_awaddr) == 3'h0);
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_held) begin
                    s_axi_bresp <= aw_bad ? `BCFG_RESP_SLVERR : `BCFG_RESP_OKAY;
                end else begin
                    s_axi_bresp <= (reg_hit(s_axi_awaddr) == 3'h0) ? `BCFG_RESP_SLVERR : `BCFG_RESP_OKAY;
                end
            end else begin
                aw_held <= aw_have;
                w_held  <= w_have;
                if (s_axi_bvalid & s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
            // each ready only while its own channel holds nothing and no response waits, so one write is under way at a time
            s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~do_write & ~s_axi_awready;
            s_axi_wready  <= ~w_have & ~s_axi_bvalid & ~do_write & ~s_axi_wready;
        end
    end

    wire [2:0] wr_hit;
    assign wr_hit = reg_hit({{(32-`BCFG_ADDR_W){1'b0}}, aw_cur}) & {3{~(aw_held & aw_bad)}};

    // register storage; only documented writable bits exist as flops  (see R06)
    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            arbiter_interleave_select  <= 1'b0;
            periph_write_buffer_enable <= 1'b0;
            area_little_endian         <= 6'h00;
            area_sram_select           <= 8'h00;
        end else if (do_write & ~(~aw_held & (reg_hit(s_axi_awaddr) == 3'h0))) begin
            if (wr_hit[0] & ws_cur[0]) begin
                arbiter_interleave_select  <= wd_cur[`BCFG_ARB_ILV_BIT];
                periph_write_buffer_enable <= wd_cur[`BCFG_ARB_PWB_BIT];
            end
            if (wr_hit[1] & ws_cur[0]) begin
                area_little_endian <= wd_cur[`BCFG_LE_MSB:`BCFG_LE_LSB];  // see R07
            end
            if (wr_hit[2] & ws_cur[1]) begin
                area_sram_select <= wd_cur[`BCFG_SRAM_MSB:`BCFG_SRAM_LSB];  // see R10
            end
        end
    end

    // read side: one read at a time, data held until rready
    reg [31:0] rd_val;
    reg [2:0]  rd_hit;
    always @* begin
        rd_hit = reg_hit(s_axi_araddr);
        rd_val = 32'h00000000;
        if (rd_hit[0]) begin
            rd_val[`BCFG_ARB_ONE_BIT] = 1'b1;  // see R04
            rd_val[`BCFG_ARB_ILV_BIT] = arbiter_interleave_select;  // bit 5 stays zero, see R05
            rd_val[`BCFG_ARB_PWB_BIT] = periph_write_buffer_enable;
        end else if (rd_hit[1]) begin
            rd_val[`BCFG_LE_MSB:`BCFG_LE_LSB] = area_little_endian;  // see R06
        end else if (rd_hit[2]) begin
            rd_val[`BCFG_SRAM_MSB:`BCFG_SRAM_LSB] = area_sram_select;  // see R06
        end
    end

    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `BCFG_RESP_OKAY;
        end else begin
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= (rd_hit == 3'h0) ? `BCFG_RESP_SLVERR : `BCFG_RESP_OKAY;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= ~s_axi_rvalid & ~do_read & ~s_axi_arready;
        end
    end

    // arbitration: fixed order dma, transfer controller, cpu; interleave only on cpu collisions
    assign side_req = dma_controller_req | data_transfer_controller_req;

    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            cpu_grant                      <= 1'b0;
            dma_controller_grant           <= 1'b0;
            data_transfer_controller_grant <= 1'b0;
            last_cpu                       <= 1'b0;
        end else begin
            cpu_grant                      <= 1'b0;
            dma_controller_grant           <= 1'b0;
            data_transfer_controller_grant <= 1'b0;
            if (arbiter_interleave_select & cpu_req & side_req) begin
                // alternate between cpu and the higher of the two side masters  (see R02)
                last_cpu <= ~last_cpu;
                if (last_cpu) begin
                    dma_controller_grant           <= dma_controller_req;
                    data_transfer_controller_grant <= ~dma_controller_req;
                end else begin
                    cpu_grant <= 1'b1;
                end
            end else if (dma_controller_req) begin
                dma_controller_grant <= 1'b1;  // see R01
                last_cpu             <= 1'b0;
            end else if (data_transfer_controller_req) begin
                data_transfer_controller_grant <= 1'b1;  // see R01
                last_cpu                       <= 1'b0;
            end else if (cpu_req) begin
                cpu_grant <= 1'b1;  // see R01
                last_cpu  <= 1'b1;
            end
        end
    end

    // write buffer steering; the external enable is sampled, so a change can miss
    // the very next access, which the bus controller tolerates  (see R13)
    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            ext_wbuf_en           <= 1'b0;
            periph_write_buffered <= 1'b0;
            periph_write_direct   <= 1'b0;
            ext_write_buffered    <= 1'b0;
            ext_write_direct      <= 1'b0;
        end else begin
            ext_wbuf_en           <= external_write_buffer_enable;
            periph_write_buffered <= periph_write_req & periph_write_buffer_enable;   // see R03
            periph_write_direct   <= periph_write_req & ~periph_write_buffer_enable;  // see R03
            ext_write_buffered    <= (ext_write_req | dma_single_write_req) & ext_wbuf_en;   // see R13
            ext_write_direct      <= (ext_write_req | dma_single_write_req) & ~ext_wbuf_en;  // see R13
        end
    end

    // areas 0 and 1 have no endian bit and stay big endian  (see R14)
    assign area_le = (ext_area >= 3'h2) ? area_little_endian[ext_area] : 1'b0;

    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            ext_bus_data        <= 32'h00000000;
            ext_little_endian   <= 1'b0;
            area_byte_ctrl_sram <= 8'h00;
        end else begin
            // internal word is big endian; only the external copy is reordered  (see R08)
            ext_bus_data        <= area_le ? le_swap(ext_wdata, ext_size) : ext_wdata;  // see R07
            ext_little_endian   <= area_le;
            // an 8-bit area masks its sram select  (see R11)
            area_byte_ctrl_sram <= area_sram_select & ~area_bus_width_control;  // see R10
        end
    end

endmodule

`default_nettype wire

// ==== bcfg_bus_config_asserts.sv ====
/* checker for the bus configuration bank: arbiter, write steering, endian and sram outputs.
   assumes it is bound to bcfg_bus_config, one sys_clk domain, rst_b active low. */
`default_nettype none
module bcfg_bus_config_asserts (
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       cpu_req,
    input wire logic       dma_controller_req,
    input wire logic       data_transfer_controller_req,
    input wire logic       cpu_grant,
    input wire logic       dma_controller_grant,
    input wire logic       data_transfer_controller_grant,
    input wire logic       periph_write_req,
    input wire logic       periph_write_buffered,
    input wire logic       periph_write_direct,
    input wire logic       ext_write_req,
    input wire logic       dma_single_write_req,
    input wire logic       ext_write_buffered,
    input wire logic       ext_write_direct,
    input wire logic [2:0] ext_area,
    input wire logic [7:0] area_bus_width_control,
    input wire logic       ext_little_endian,
    input wire logic [7:0] area_byte_ctrl_sram
);
    logic [1:0] live_cnt;
    wire        live = live_cnt == 2'h3;
    wire  [2:0] grants = {cpu_grant, dma_controller_grant, data_transfer_controller_grant};
    // the design's own reset trails rst_b by two edges, so hold off until then
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b) live_cnt <= 2'h0;
        else if (!live) live_cnt <= live_cnt + 2'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_conflict;
        cpu_req && dma_controller_req;
    endsequence
    AST_GRANT_ONEHOT: assert property (live |-> $onehot0(grants)) else $error("two grants at once");
    AST_DMA_TOP: assert property (live && dma_controller_req && !cpu_req |=> grants == 3'b010)
        else $error("dma not granted");
    AST_XFER_LOW: assert property (live && data_transfer_controller_req && !cpu_req && !dma_controller_req
        |=> grants == 3'b001) else $error("transfer controller not granted");
    AST_CPU_ALONE: assert property (live && cpu_req && !dma_controller_req && !data_transfer_controller_req
        |=> grants == 3'b100) else $error("cpu not granted");
    AST_NO_REQ: assert property (live && !cpu_req && !dma_controller_req && !data_transfer_controller_req
        |=> grants == 3'b000) else $error("grant without request");
    AST_CPU_NOT_TWICE: assert property (live ##0 s_conflict ##1 (s_conflict and cpu_grant) |=> !cpu_grant)
        else $error("cpu kept bus under conflict");
    AST_PWB_STEER: assert property (live && periph_write_req
        |=> periph_write_buffered != periph_write_direct) else $error("peripheral write not steered");
    AST_PWB_QUIET: assert property (live && !periph_write_req
        |=> !periph_write_buffered && !periph_write_direct) else $error("peripheral steer without request");
    AST_EXT_STEER: assert property (live && (ext_write_req || dma_single_write_req)
        |=> ext_write_buffered != ext_write_direct) else $error("external write not steered");
    AST_AREA01_BIG: assert property (live && ext_area < 3'h2 |=> !ext_little_endian)
        else $error("area 0 or 1 little endian");
    AST_SRAM_8BIT: assert property (live |=> (area_byte_ctrl_sram & $past(area_bus_width_control)) == 8'h0)
        else $error("byte control on 8-bit area");
endmodule
bind bcfg_bus_config bcfg_bus_config_asserts chk_u (.sys_clk, .rst_b, .cpu_req, .dma_controller_req,
    .data_transfer_controller_req, .cpu_grant, .dma_controller_grant, .data_transfer_controller_grant,
    .periph_write_req, .periph_write_buffered, .periph_write_direct, .ext_write_req, .dma_single_write_req,
    .ext_write_buffered, .ext_write_direct, .ext_area, .area_bus_width_control, .ext_little_endian,
    .area_byte_ctrl_sram);
`default_nettype wire

// ==== test_bus_arbiter_endian_sram_config.sv ====
/* self-checking bench for the bus configuration bank, registers reached over axi4-lite.
   assumes bcfg_bus_config and its bound checker are compiled beforehand. */
`include "bcfg_defs.vh"
`default_nettype none
module test_bus_arbiter_endian_sram_config;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, rst_b = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, ext_wdata = '0, rdata, ebd;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wrd, bv, arr, rv;
    logic [1:0]  bresp, rresp, size = '0;
    logic [3:0]  ws = 4'hf;
    logic        cpu_r = 0, dma_r = 0, xfc_r = 0, pw_r = 0, ew_r = 0, ds_r = 0, ew_en = 0;
    logic        g_cpu, g_dma, g_xfc, pwb_o, pwd_o, ewb_o, ewd_o, ele;
    logic [2:0]  area = '0;
    logic [7:0]  bw = '0, sram_o, endi, sr;
    logic        ilv, pwb, prev_cpu = 0, chk_req = 0, chk_go = 0;
    logic [47:0] pq[$];
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          n_fail = 0, cmp_count = 0;
    always #25 sys_clk = ~sys_clk;
    bcfg_bus_config dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .cpu_req(cpu_r), .dma_controller_req(dma_r), .data_transfer_controller_req(xfc_r), .cpu_grant(g_cpu),
        .dma_controller_grant(g_dma), .data_transfer_controller_grant(g_xfc), .periph_write_req(pw_r),
        .ext_write_req(ew_r), .dma_single_write_req(ds_r), .external_write_buffer_enable(ew_en),
        .periph_write_buffered(pwb_o), .periph_write_direct(pwd_o), .ext_write_buffered(ewb_o),
        .ext_write_direct(ewd_o), .ext_area(area), .ext_size(size), .ext_wdata(ext_wdata),
        .area_bus_width_control(bw), .ext_bus_data(ebd), .ext_little_endian(ele), .area_byte_ctrl_sram(sram_o));
    task automatic stop_test;
        if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wrd === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
        // one edge between transfers, so the next call never re-raises bready in this step
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a; arv <= 1'b1; rre <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rre <= 1'b0;
        @(posedge sys_clk);
    endtask
    // one cycle of random side-band traffic; the expected outputs are queued for two edges later
    task automatic step(input bit idle);
        logic [2:0]  rq3, wq, ar, g;
        logic [1:0]  sz;
        logic [7:0]  bv8;
        logic [31:0] d, x;
        logic        le;
        rq3 = idle ? 3'h0 : 3'($urandom);
        wq = idle ? 3'h0 : 3'($urandom);
        ar = 3'($urandom);
        sz = 2'($urandom_range(2));
        bv8 = 8'($urandom);
        d = $urandom;
        if (ilv && rq3[2] && rq3[1:0] != 2'h0 && !prev_cpu) g = 3'b100;
        else if (rq3[1]) g = 3'b010;
        else if (rq3[0]) g = 3'b001;
        else g = {rq3[2], 2'b00};
        if (g != 3'h0) prev_cpu = g[2]; // the arbiter keeps its turn through cycles without requests
        le = ar > 3'h1 && endi[ar];
        x = !le || sz == `BCFG_SIZE_BYTE ? d : sz == `BCFG_SIZE_WORD ? {d[23:16], d[31:24], d[7:0], d[15:8]} :
            {d[7:0], d[15:8], d[23:16], d[31:24]};
        pq.push_back({g, x, le, sr & ~bv8, wq[2] & pwb, wq[2] & !pwb, |wq[1:0] & ew_en, |wq[1:0] & !ew_en});
        {cpu_r, dma_r, xfc_r} <= rq3;
        {pw_r, ew_r, ds_r} <= wq;
        area <= ar; size <= sz; bw <= bv8; ext_wdata <= d; chk_req <= 1'b1;
        @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        chk_go <= chk_req;
        if (chk_go) chk({g_cpu, g_dma, g_xfc, ebd, ele, sram_o, pwb_o, pwd_o, ewb_o, ewd_o}, pq.pop_front());
        if (rv === 1'b1 && rre) chk(48'({rresp, rdata}), 48'(rq.pop_front()));
        if (bv === 1'b1 && bre) chk(48'(bresp), 48'(bq.pop_front()));
    end
    initial begin
        #2000000;
        n_fail++;
        stop_test();
    end
    initial begin
        void'($urandom(18));
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd({28'h0, `BCFG_OFF_ARB}, {`BCFG_RESP_OKAY, 32'h2});
        rd({28'h0, `BCFG_OFF_ENDIAN}, {`BCFG_RESP_OKAY, 32'h0});
        rd({28'h0, `BCFG_OFF_SRAM}, {`BCFG_RESP_OKAY, 32'h0});
        wr(32'hc, 32'hffff, `BCFG_RESP_SLVERR);
        rd(32'hc, {`BCFG_RESP_SLVERR, 32'h0});
        for (int m = 0; m < 4; m++) begin
            {ilv, pwb} = 2'(m);
            // no code or stack lives in the external areas here, so any endian mix is legal
            endi = 8'($urandom) & 8'hfc;
            sr = 8'($urandom);
            ew_en <= ilv ^ pwb;
            // reserved bit 1 written as one and bit 5 as zero; bits 2, 3, 6 and 7 written as ones
            wr({28'h0, `BCFG_OFF_ARB}, {24'h0, 8'hce | {3'h0, ilv, 3'h0, pwb}}, `BCFG_RESP_OKAY);
            rd({28'h0, `BCFG_OFF_ARB}, {`BCFG_RESP_OKAY, 24'h0, 3'h0, ilv, 3'h1, pwb});
            wr({28'h0, `BCFG_OFF_ENDIAN}, {24'h0, endi | 8'h03}, `BCFG_RESP_OKAY);
            rd({28'h0, `BCFG_OFF_ENDIAN}, {`BCFG_RESP_OKAY, 24'h0, endi});
            // burst-rom and multiplex selections live outside this block and stay clear
            wr({28'h0, `BCFG_OFF_SRAM}, {16'h0, sr, 8'hff}, `BCFG_RESP_OKAY);
            ws <= 4'h1;
            // lane 1 disabled: the sram select bits must keep their value
            wr({28'h0, `BCFG_OFF_SRAM}, {16'h0, ~sr, 8'hff}, `BCFG_RESP_OKAY);
            ws <= 4'hf;
            rd({28'h0, `BCFG_OFF_SRAM}, {`BCFG_RESP_OKAY, 16'h0, sr, 8'h0});
            step(1'b1);
            repeat (40) step(1'b0);
            // leave the masters idle so the arbiter's turn stays put across the register writes
            step(1'b1);
            chk_req <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
        stop_test();
    end
endmodule
`default_nettype wire
